// ===== dv/reload_countdown_timer_props.sv
// port checker for the reload countdown timer
`timescale 1ns/1ns
`include "timer_defines.vh"
module timer_props
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic tx_end_i,
  input wire logic rx_bit_i,
  input wire logic card_interface_input_pin_i,
  input wire logic first_auxiliary_pin_i,
  input wire logic timer_running_o,
  input wire logic irq_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire logic taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic reg_wr = taken && wb_we_i && wb_sel_i[0];
  wire logic ctl_wr = reg_wr && wb_adr_i[9:2] == `IDX_TIMER_CONTROL;
  wire logic start_req = ctl_wr && wb_dat_i[`CTRL_START_NOW];
  wire logic start_any = start_req || tx_end_i;
  sequence s_start;
    start_req;
  endsequence
  // start wins over stop, so only a pure stop is judged
  sequence s_stop;
    ctl_wr && wb_dat_i[3:2] == 2'h2 && !tx_end_i;
  endsequence
  sequence s_mask_off;
    reg_wr && wb_adr_i[9:2] == `IDX_IRQ_MASK && !wb_dat_i[0];
  endsequence
  a_ack_answers: assert property (taken |=> wb_ack_o)
    else $error("request not acknowledged on the next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");
  a_ack_caused: assert property (wb_ack_o |-> $past(taken))
    else $error("acknowledge without a request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside acknowledge");
  a_unmapped_zero: assert property (taken && !wb_we_i && wb_adr_i[9:2] == 8'h30
    |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_start_runs: assert property (s_start |=> ##1 timer_running_o)
    else $error("timer not running after start");
  a_stop_halts: assert property (s_stop |=> ##1 !timer_running_o)
    else $error("timer still running after stop");
  a_mask_quiet: assert property (s_mask_off |=> ##1 !irq_o)
    else $error("interrupt high while masked");
  a_run_cause: assert property ($rose(timer_running_o) |-> $past(start_any, 2))
    else $error("timer started without a start event");
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the reload countdown timer
`timescale 1ns/1ns
`include "timer_defines.vh"
module tb_top;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0;
  logic we = 1'h0;
  logic tx_end = 1'h0;
  logic rx_bit = 1'h0;
  logic card_pin = 1'h0;
  logic aux_pin = 1'h0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h1;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic run;
  logic irq;
  logic [7:0] rd;
  logic [15:0] v;
  int fail_count = 0;
  int check_count = 0;
  always #20 clk_i = ~clk_i;
  reload_countdown_timer reload_countdown_timer_i
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(cyc),
    .wb_stb_i(cyc),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(wdat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .tx_end_i(tx_end),
    .rx_bit_i(rx_bit),
    .card_interface_input_pin_i(card_pin),
    .first_auxiliary_pin_i(aux_pin),
    .timer_running_o(run),
    .irq_o(irq)
  );
  task automatic summarize();
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // accumulator jitter and bus latency allow a small spread
  task automatic chk_rng(string n, int e, logic [15:0] g);
    check_count++;
    if (^g === 1'bx || g + 4 < e || g > e + 4)
    begin
      fail_count++;
      $display("unexpected %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(logic w, logic [7:0] idx, logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'h1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= {24'h00_0000, d};
    for (n = 0; n < 50 && ack !== 1'b1; n++)
      @(posedge clk_i);
    rd = rdat[7:0];
    cyc <= 1'h0;
    if (n >= 50)
    begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic wr(logic [7:0] idx, logic [7:0] d);
    bus(1'h1, idx, d);
  endtask
  task automatic rdc(string n, logic [7:0] idx, logic [7:0] e);
    bus(1'h0, idx, 8'h00);
    chk(n, {8'h00, e}, {8'h00, rd});
  endtask
  task automatic cnt();
    bus(1'h0, `IDX_COUNT_HIGH, 8'h00);
    v[15:8] = rd;
    bus(1'h0, `IDX_COUNT_LOW, 8'h00);
    v[7:0] = rd;
  endtask
  task automatic setup(logic [7:0] m, logic [7:0] p, logic [15:0] r);
    wr(`IDX_TIMER_MODE, m);
    wr(`IDX_PRESCALE_LOW, p);
    wr(`IDX_RELOAD_HIGH, r[15:8]);
    wr(`IDX_RELOAD_LOW, r[7:0]);
  endtask
  task automatic pulse(logic t, int k);
    repeat (k)
    begin
      @(posedge clk_i);
      tx_end <= t;
      rx_bit <= !t;
      @(posedge clk_i);
      tx_end <= 1'h0;
      rx_bit <= 1'h0;
    end
    idle(3);
  endtask
  task automatic t_regs();
    for (int i = 8'h2a; i < 8'h30; i++)
      rdc("reset value", i[7:0], 8'h00);
    rdc("even select", `IDX_TIMER_CONTROL, 8'h00);
    for (int i = 8'h2b; i < 8'h31; i++)
      wr(i[7:0], 8'ha5);
    for (int i = 8'h2b; i < 8'h31; i++)
      rdc("readback", i[7:0], i < 8'h2e ? 8'ha5 : 8'h00);
    // lane zero disabled: the write must be ignored
    sel <= 4'h0;
    wr(`IDX_PRESCALE_LOW, 8'h3c);
    sel <= 4'h1;
    rdc("lane disabled write", `IDX_PRESCALE_LOW, 8'ha5);
  endtask
  task automatic t_load();
    setup(8'h0f, 8'hff, 16'h1234);
    wr(`IDX_TIMER_CONTROL, 8'h04);
    cnt();
    chk("loaded count", 16'h1234, v);
    wr(`IDX_RELOAD_HIGH, 8'h56);
    wr(`IDX_RELOAD_LOW, 8'h78);
    cnt();
    chk("count after reload write", 16'h1234, v);
    wr(`IDX_TIMER_CONTROL, 8'h04);
    cnt();
    chk("restarted count", 16'h5678, v);
  endtask
  task automatic t_rate(logic [7:0] m, logic [7:0] p, logic [7:0] c, int n);
    logic [15:0] held;
    setup(m, p, 16'h12ff);
    wr(`IDX_TIMER_CONTROL, c);
    idle(n);
    cnt();
    chk_rng("ticks", n * 13560 / (25000 * (2 * {m[3:0], p} + 1 + c[0])), 16'h12ff - v);
    wr(`IDX_TIMER_CONTROL, 8'h08);
    cnt();
    held = v;
    idle(300);
    cnt();
    chk("stopped count", held, v);
  endtask
  task automatic t_irq();
    int n;
    setup(8'h00, 8'h00, 16'h0020);
    wr(`IDX_IRQ_MASK, 8'h01);
    wr(`IDX_TIMER_CONTROL, 8'h04);
    for (n = 0; n < 200 && irq !== 1'b1; n++)
      @(posedge clk_i);
    chk_rng("cycles to interrupt", 32 * 25000 / 13560, n[15:0]);
    idle(2);
    chk("running at zero", 16'h0000, {15'h0000, run});
    rdc("flag", `IDX_IRQ_STATUS, 8'h01);
    wr(`IDX_IRQ_STATUS, 8'h01);
    idle(2);
    chk("cleared interrupt", 16'h0000, {15'h0000, irq});
    wr(`IDX_IRQ_MASK, 8'h00);
    wr(`IDX_TIMER_CONTROL, 8'h04);
    idle(100);
    chk("masked interrupt", 16'h0000, {15'h0000, irq});
    rdc("masked flag", `IDX_IRQ_STATUS, 8'h01);
    wr(`IDX_IRQ_STATUS, 8'h01);
  endtask
  task automatic t_reload();
    setup(8'h10, 8'h00, 16'h0010);
    wr(`IDX_TIMER_CONTROL, 8'h04);
    idle(200);
    chk("running after zero", 16'h0001, {15'h0000, run});
    cnt();
    // phase of the reload cycle is not fixed, so only the bound is judged
    chk("reloaded range", 16'h0001, {15'h0000, v <= 16'h0010});
    wr(`IDX_TIMER_CONTROL, 8'h08);
  endtask
  task automatic t_auto(logic [7:0] c);
    setup(8'h8f, 8'hff, 16'h0300);
    wr(`IDX_TIMER_CONTROL, c);
    pulse(1'h1, 1);
    chk("auto started", 16'h0001, {15'h0000, run});
    pulse(1'h0, 4);
    chk("after four bits", 16'h0001, {15'h0000, run});
    pulse(1'h0, 1);
    chk("after fifth bit", {15'h0000, c[1]}, {15'h0000, run});
    wr(`IDX_TIMER_CONTROL, 8'h08);
  endtask
  // the wrong pin opens first, so a swapped select shows
  task automatic t_gate(logic [1:0] g);
    setup({1'h0, g, 5'h00}, 8'h00, 16'h00ff);
    card_pin <= g[1];
    aux_pin <= g[0];
    wr(`IDX_TIMER_CONTROL, 8'h04);
    idle(50);
    cnt();
    chk("gated count", 16'h00ff, v);
    card_pin <= g[0];
    aux_pin <= g[1];
    idle(50);
    cnt();
    chk_rng("open gate ticks", 27, 16'h00ff - v);
    card_pin <= 1'h0;
    aux_pin <= 1'h0;
  endtask
  initial
  begin
    idle(16);
    rst_i <= 1'h0;
    t_regs();
    t_load();
    t_rate(8'h00, 8'h02, 8'h04, 2000);
    t_rate(8'h00, 8'h02, 8'h05, 2000);
    t_rate(8'h01, 8'h00, 8'h04, 20000);
    t_irq();
    t_reload();
    t_auto(8'h00);
    t_auto(8'h02);
    t_gate(2'h1);
    t_gate(2'h2);
    summarize();
  end
  initial
  begin
    idle(90000);
    fail_count++;
    summarize();
  end
endmodule
bind reload_countdown_timer timer_props timer_props_i
(
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .tx_end_i(tx_end_i),
  .rx_bit_i(rx_bit_i),
  .card_interface_input_pin_i(card_interface_input_pin_i),
  .first_auxiliary_pin_i(first_auxiliary_pin_i),
  .timer_running_o(timer_running_o),
  .irq_o(irq_o)
);

// ===== rtl/pin_sync.v
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module pin_sync
#(
  parameter WIDTH = 2
)
(
  input wire clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule

// ===== rtl/reload_countdown_timer.v
// reload countdown timer with wishbone register slave and interrupt
//
// Contract
// - Low prescaler byte lives in its own 8-bit read/write register.
// - Prescaler is 12 bits: mode nibble above low byte; even select resets zero.
// - Even select zero: tick rate is 13.56 MHz over 2*setting+1.
// - Even select one: tick rate is 13.56 MHz over 2*setting+2.
// - Reload high byte is read/write at offset 2Ch, reset zero.
// - Reload low byte is read/write at offset 2Dh, reset zero.
// - Every start event loads the full 16-bit reload value.
// - Reload writes do not disturb counting; used at next start.
// - Counter high byte readable, read-only, at offset 2Eh.
// - Counter low byte readable, read-only, at offset 2Fh.
// - Auto start after transmission; stop after fifth received bit unless multi-receive.
// - Without auto reload, count to zero then raise timer interrupt request.
// - With auto reload, reload at zero and keep counting down.
`timescale 1ns/1ns
`include "timer_defines.vh"
module reload_countdown_timer
#(
  parameter PRESC_WIDTH = 12,
  parameter COUNT_WIDTH = 16
)
(
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire tx_end_i,
  input wire rx_bit_i,
  input wire card_interface_input_pin_i,
  input wire first_auxiliary_pin_i,
  output reg timer_running_o,
  output reg irq_o
);

  // byte-lane merge used by the mode, prescaler and reload registers
  function [7:0] lane0_write;
    input [7:0] old_value;
    input [31:0] data;
    input [3:0] sel;
    begin
      lane0_write = sel[0] ? data[7:0] : old_value;
    end
  endfunction

  // -------- register state --------
  reg [7:0] timer_mode_reg;
  reg [7:0] prescale_low_bits_reg;
  reg [7:0] reload_high_bits_reg;
  reg [7:0] reload_low_bits_reg;
  reg [1:0] control_reg;
  reg irq_status_reg;
  reg irq_mask_reg;

  // -------- timer state --------
  reg [COUNT_WIDTH-1:0] count_reg;
  reg [COUNT_WIDTH-1:0] count_next;
  reg running_reg;
  reg running_next;
  reg timer_event_next;
  reg [2:0] rx_bits_reg;
  reg rx_armed_reg;
  reg [15:0] ref_acc_reg;
  reg ref_en_reg;

  // -------- decoded fields --------
  wire auto_start_after_tx;
  wire [1:0] gate_source_select;
  wire auto_reload_enable;
  wire [3:0] prescale_high_nibble;
  wire even_divide_select;
  wire multi_receive_mode;
  wire [PRESC_WIDTH-1:0] prescale_setting;
  wire [COUNT_WIDTH-1:0] reload_value;

  assign auto_start_after_tx = timer_mode_reg[`MODE_AUTO_START];
  assign gate_source_select = timer_mode_reg[`MODE_GATE_HI:`MODE_GATE_LO];
  assign auto_reload_enable = timer_mode_reg[`MODE_AUTO_RELOAD];
  assign prescale_high_nibble = timer_mode_reg[`MODE_PRESC_HI:`MODE_PRESC_LO];
  assign even_divide_select = control_reg[`CTRL_EVEN_DIVIDE];
  assign multi_receive_mode = control_reg[`CTRL_MULTI_RECEIVE];
  assign prescale_setting = {prescale_high_nibble, prescale_low_bits_reg};
  assign reload_value = {reload_high_bits_reg, reload_low_bits_reg};

  // -------- bus decode --------
  wire bus_req;
  wire bus_write;
  wire [7:0] reg_index;

  // one answer per request; the ack cycle itself is not a new request
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_write = bus_req && wb_we_i;
  assign reg_index = wb_adr_i[9:2];

  wire ctrl_write;
  wire start_now;
  wire stop_now;

  assign ctrl_write = bus_write && (reg_index == `IDX_TIMER_CONTROL) && wb_sel_i[0];
  assign start_now = ctrl_write && wb_dat_i[`CTRL_START_NOW];
  assign stop_now = ctrl_write && wb_dat_i[`CTRL_STOP_NOW];

  // -------- gate pins --------
  wire [1:0] pins_sync;

  pin_sync
  #(
    .WIDTH(2)
  )
  u_pin_sync
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({first_auxiliary_pin_i, card_interface_input_pin_i}),
    .sync_o(pins_sync)
  );

  reg gate_open;

  // gate source choice; code 11 is treated as ungated
  always @*
  begin
    case (gate_source_select)
      `GATE_NONE:
        gate_open = 1'b1;
      `GATE_CARD_PIN:
        gate_open = pins_sync[0];
      `GATE_AUX_PIN:
        gate_open = pins_sync[1];
      default:
        gate_open = 1'b1;
    endcase
  end

  // -------- 13.56 MHz reference enable --------
  // fractional accumulator: average pulse rate is exact, spacing jitters by one clock
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_acc_reg <= 16'h0000;
      ref_en_reg <= 1'b0;
    end
    else if (ref_acc_reg + `REF_RATE_KHZ >= `CLK_RATE_KHZ)
    begin
      ref_acc_reg <= ref_acc_reg + `REF_RATE_KHZ - `CLK_RATE_KHZ;
      ref_en_reg <= 1'b1;
    end
    else
    begin
      ref_acc_reg <= ref_acc_reg + `REF_RATE_KHZ;
      ref_en_reg <= 1'b0;
    end
  end

  // -------- start and stop events --------
  wire auto_start;
  wire auto_stop;
  wire start_event;
  wire stop_event;

  // automatic start at end of transmission
  assign auto_start = auto_start_after_tx && tx_end_i;
  // stop on the fifth received bit unless multi-receive
  assign auto_stop = auto_start_after_tx && !multi_receive_mode && rx_armed_reg &&
                     rx_bit_i && (rx_bits_reg == `RX_STOP_BITS - 3'h1);
  assign start_event = start_now || auto_start;
  assign stop_event = stop_now || auto_stop;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_bits_reg <= 3'h0;
      rx_armed_reg <= 1'b0;
    end
    else if (auto_start)
    begin
      rx_bits_reg <= 3'h0;
      rx_armed_reg <= 1'b1;
    end
    else if (rx_armed_reg && rx_bit_i)
    begin
      rx_bits_reg <= rx_bits_reg + 3'h1;
      if (rx_bits_reg == `RX_STOP_BITS - 3'h1)
      begin
        rx_armed_reg <= 1'b0;
      end
    end
  end

  // -------- prescaler --------
  wire tick;

  // divide 2*setting+1 or 2*setting+2 reference pulses
  tick_prescaler
  #(
    .SET_WIDTH(PRESC_WIDTH)
  )
  u_tick_prescaler
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(start_event || !running_reg),
    .ref_en_i(ref_en_reg && gate_open),
    .setting_i(prescale_setting),
    .even_i(even_divide_select),
    .tick_o(tick)
  );

  // -------- count-down engine --------
  always @*
  begin
    count_next = count_reg;
    running_next = running_reg;
    timer_event_next = 1'b0;
    if (start_event)
    begin
      count_next = reload_value;
      running_next = 1'b1;
    end
    else if (stop_event)
    begin
      running_next = 1'b0;
    end
    else if (running_reg && tick)
    begin
      if (count_reg == {COUNT_WIDTH{1'b0}})
      begin
        if (auto_reload_enable)
        begin
          count_next = reload_value;
        end
        else
        begin
          running_next = 1'b0;
          timer_event_next = 1'b1;
        end
      end
      else
      begin
        count_next = count_reg - {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
        if (count_reg == {{(COUNT_WIDTH-1){1'b0}}, 1'b1})
        begin
          timer_event_next = 1'b1;
          running_next = auto_reload_enable;
        end
      end
    end
  end

  // a start event, or a tick at zero with auto reload, copies the reload registers into the count
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_reg <= `RST_COUNT;
      running_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      running_reg <= running_next;
    end
  end

  // -------- register writes --------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer_mode_reg <= `RST_TIMER_MODE;
      prescale_low_bits_reg <= `RST_PRESCALE_LOW;
      reload_high_bits_reg <= `RST_RELOAD;
      reload_low_bits_reg <= `RST_RELOAD;
      control_reg <= `RST_CONTROL;
      irq_mask_reg <= `RST_IRQ_MASK;
    end
    else if (bus_write)
    begin
      case (reg_index)
        `IDX_TIMER_MODE:
          timer_mode_reg <= lane0_write(timer_mode_reg, wb_dat_i, wb_sel_i);
        `IDX_PRESCALE_LOW:
          prescale_low_bits_reg <= lane0_write(prescale_low_bits_reg, wb_dat_i, wb_sel_i);
        `IDX_RELOAD_HIGH:
          reload_high_bits_reg <= lane0_write(reload_high_bits_reg, wb_dat_i, wb_sel_i);
        `IDX_RELOAD_LOW:
          reload_low_bits_reg <= lane0_write(reload_low_bits_reg, wb_dat_i, wb_sel_i);
        `IDX_TIMER_CONTROL:
          if (wb_sel_i[0])
          begin
            control_reg <= wb_dat_i[`CTRL_MULTI_RECEIVE:`CTRL_EVEN_DIVIDE];
          end
        `IDX_IRQ_MASK:
          if (wb_sel_i[0])
          begin
            irq_mask_reg <= wb_dat_i[`IRQ_TIMER];
          end
        default:
          control_reg <= control_reg;
      endcase
    end
  end

  // -------- interrupt --------
  wire irq_clear;

  assign irq_clear = bus_write && (reg_index == `IDX_IRQ_STATUS) && wb_sel_i[0] &&
                     wb_dat_i[`IRQ_TIMER];

  // a zero crossing in the clearing cycle still sets the flag
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_status_reg <= 1'b0;
      irq_o <= 1'b0;
      timer_running_o <= 1'b0;
    end
    else
    begin
      if (timer_event_next)
      begin
        irq_status_reg <= 1'b1;
      end
      else if (irq_clear)
      begin
        irq_status_reg <= 1'b0;
      end
      irq_o <= irq_status_reg && irq_mask_reg;
      timer_running_o <= running_reg;
    end
  end

  // -------- read mux and acknowledge --------
  reg [7:0] read_byte;

  always @*
  begin
    case (reg_index)
      `IDX_TIMER_MODE:
        read_byte = timer_mode_reg;
      `IDX_PRESCALE_LOW:
        read_byte = prescale_low_bits_reg;
      `IDX_RELOAD_HIGH:
        read_byte = reload_high_bits_reg;
      `IDX_RELOAD_LOW:
        read_byte = reload_low_bits_reg;
      `IDX_COUNT_HIGH:
        read_byte = count_reg[COUNT_WIDTH-1:COUNT_WIDTH-8];
      `IDX_COUNT_LOW:
        read_byte = count_reg[7:0];
      `IDX_TIMER_CONTROL:
        read_byte = {6'h00, control_reg};
      `IDX_TIMER_STATUS:
        read_byte = {3'h0, rx_bits_reg, gate_open, running_reg};
      `IDX_IRQ_STATUS:
        read_byte = {7'h00, irq_status_reg};
      `IDX_IRQ_MASK:
        read_byte = {7'h00, irq_mask_reg};
      default:
        read_byte = 8'h00;
    endcase
  end

  // every address answers after one cycle; unmapped ones read zero
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
      begin
        wb_dat_o <= {24'h00_0000, read_byte};
      end
      else
      begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

endmodule

// ===== rtl/tick_prescaler.v
// timer tick prescaler: divides reference pulses by 2*setting+1 or 2*setting+2
`timescale 1ns/1ns
`include "timer_defines.vh"
module tick_prescaler
#(
  parameter SET_WIDTH = 12
)
(
  input wire clk_i,
  input wire rst_i,
  input wire clear_i,
  input wire ref_en_i,
  input wire [SET_WIDTH-1:0] setting_i,
  input wire even_i,
  output reg tick_o
);

  reg [SET_WIDTH:0] count_reg;
  wire [SET_WIDTH:0] terminal;

  // last count value before the tick: 2*setting or 2*setting+1
  assign terminal = {setting_i, even_i};

  always @(posedge clk_i)
  begin
    if (rst_i || clear_i)
    begin
      count_reg <= {(SET_WIDTH+1){1'b0}};
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= 1'b0;
      if (ref_en_i)
      begin
        if (count_reg >= terminal)
        begin
          count_reg <= {(SET_WIDTH+1){1'b0}};
          tick_o <= 1'b1;
        end
        else
        begin
          count_reg <= count_reg + 1'b1;
        end
      end
    end
  end

endmodule

// ===== rtl/timer_defines.vh
// register map, field positions and timing constants of the reload countdown timer
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_TIMER_MODE 8'h2a
`define IDX_PRESCALE_LOW 8'h2b
`define IDX_RELOAD_HIGH 8'h2c
`define IDX_RELOAD_LOW 8'h2d
`define IDX_COUNT_HIGH 8'h2e
`define IDX_COUNT_LOW 8'h2f
`define IDX_TIMER_CONTROL 8'h40
`define IDX_TIMER_STATUS 8'h41
`define IDX_IRQ_STATUS 8'h42
`define IDX_IRQ_MASK 8'h43

// reset values
`define RST_TIMER_MODE 8'h00
`define RST_PRESCALE_LOW 8'h00
`define RST_RELOAD 8'h00
`define RST_COUNT 16'h0000
`define RST_CONTROL 2'h0
`define RST_IRQ_MASK 1'h0

// timer mode register fields
`define MODE_AUTO_START 7
`define MODE_GATE_HI 6
`define MODE_GATE_LO 5
`define MODE_AUTO_RELOAD 4
`define MODE_PRESC_HI 3
`define MODE_PRESC_LO 0

// timer control register fields
`define CTRL_EVEN_DIVIDE 0
`define CTRL_MULTI_RECEIVE 1
`define CTRL_START_NOW 2
`define CTRL_STOP_NOW 3

// timer status register fields
`define STAT_RUNNING 0
`define STAT_GATE_OPEN 1
`define STAT_RXBITS_LO 2

// interrupt status and mask field
`define IRQ_TIMER 0

// gate source encodings
`define GATE_NONE 2'h0
`define GATE_CARD_PIN 2'h1
`define GATE_AUX_PIN 2'h2

// reference and system clock rates in kHz
`define REF_RATE_KHZ 16'd13560
`define CLK_RATE_KHZ 16'd25000

// received bits after which the auto-started timer stops
`define RX_STOP_BITS 3'h5

`endif
